/* mii_port_pkg.sv */
// Purpose: shared constants and state types of the mii data port
// Assumes: system clock 50 MHz; link clock is the pin-level tx clock
// Notes: byte addresses on the register bus, one word per register
`default_nettype none

package mii_port_pkg;

    // ---------------------------------------------------------------
    // clocking
    // ---------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned RATE_FAST_HZ = 25_000_000;
    localparam int unsigned RATE_SLOW_HZ = 2_500_000;
    localparam int unsigned HALF_FAST = SYS_CLK_HZ / (2 * RATE_FAST_HZ);
    localparam int unsigned HALF_SLOW = SYS_CLK_HZ / (2 * RATE_SLOW_HZ);
    localparam int DIV_W = 4;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam int STAT_CRS = 0;
    localparam int STAT_COL = 1;
    localparam int STAT_TX_BUSY = 2;
    localparam int STAT_RX_DV = 3;
    localparam int STAT_ISOLATED = 4;

    // code group sent in place of data on a transmit error at 100 Mbps
    localparam logic [4:0] INVALID_SYM = 5'h04;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic slave_clock;
        logic symbol_mode;
        logic repeater_mode;
        logic full_duplex;
        logic speed_100;
    } ctrl_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        ctrl_t ctrl;
        logic [31:0] readdata;
        logic [DIV_W-1:0] div;
        logic link_clk;
        logic [4:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic col;
        logic crs;
        logic take;
        logic tri_meta;
        logic tri_s;
        logic col_meta;
        logic col_s;
        logic busy_meta;
        logic busy_s;
    } core_state_t;

    localparam core_state_t CORE_RESET = '{
        bus: BUS_IDLE, ctrl: ctrl_t'(CTRL_RESET), default: '0};

    typedef struct packed {
        logic sym_meta;
        logic sym_s;
        logic fast_meta;
        logic fast_s;
        logic [4:0] sym;
        logic valid;
        logic invalid;
    } tx_state_t;

    localparam tx_state_t TX_RESET = '{default: '0};

endpackage : mii_port_pkg

`default_nettype wire

/* tx_link_if.sv */
// Purpose: carrier between the port core and the transmit capture
// Assumes: core side on sys_clk, capture side on the tx clock
// Notes: every signal is a level; each side synchronises what it reads
`default_nettype none

interface tx_link_if;
    logic symbol_mode;
    logic speed_100;
    logic tx_busy;

    modport core (output symbol_mode, output speed_100, input tx_busy);
    modport capture (input symbol_mode, input speed_100, output tx_busy);
endinterface : tx_link_if

`default_nettype wire

/* mii_tx_capture.sv */
// Purpose: samples the mac transmit nibble on the tx clock
// Assumes: txd, tx_en, tx_er change with the tx clock pin
// Notes: mode bits arrive from sys_clk and are synchronised here
`default_nettype none

module mii_tx_capture
    import mii_port_pkg::*;
(
    // link clock and system reset
    input wire logic tx_clk,
    input wire logic reset_n,
    // core side
    tx_link_if.capture link,
    // mac transmit pins
    input wire logic [4:0] txd,
    input wire logic tx_en,
    input wire logic tx_er,
    // line side
    output logic [4:0] line_tx_sym,
    output logic line_tx_valid,
    output logic line_tx_invalid
);
    import mii_port_pkg::*;

    tx_state_t s;
    tx_state_t next_s;
    logic rst_meta;
    logic rst_s;

    // ---------------------------------------------------------------
    // reset crossing
    // ---------------------------------------------------------------
    // asserts at once, since a sourced tx clock is stopped during reset;
    // release still passes both flops on the tx clock
    always_ff @(posedge tx_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_s <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // capture
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sym_meta = link.symbol_mode;
        next_s.sym_s = s.sym_meta;
        next_s.fast_meta = link.speed_100;
        next_s.fast_s = s.fast_meta;
        next_s.valid = tx_en;
        // errors only corrupt the line at 100 Mbps
        next_s.invalid = tx_en & tx_er & s.fast_s;
        if (!tx_en) begin
            next_s.sym = '0;
        end else if (next_s.invalid) begin
            next_s.sym = INVALID_SYM;
        end else begin
            next_s.sym = {txd[4] & s.sym_s, txd[3:0]};
        end
    end

    always_ff @(posedge tx_clk) begin
        if (!rst_s) begin
            s <= TX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign line_tx_sym = s.sym;
    assign line_tx_valid = s.valid;
    assign line_tx_invalid = s.invalid;
    assign link.tx_busy = s.valid;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge tx_clk);
    endclocking
    default disable iff (!rst_s);

    a_tx_bit4_ignored: assert property (
        $past(tx_en) && !$past(s.sym_s) && !$past(next_s.invalid)
        |-> line_tx_sym[4] == 1'b0)
        else $error("fifth transmit bit passed outside symbol mode");

    a_tx_err_symbol: assert property (
        $past(tx_en && tx_er && s.fast_s)
        |-> line_tx_invalid && line_tx_sym == INVALID_SYM)
        else $error("transmit error did not yield invalid symbol");

    a_tx_err_slow: assert property (
        !$past(s.fast_s) |-> !line_tx_invalid)
        else $error("invalid symbol sent at 10 Mbps");

endmodule : mii_tx_capture

`default_nettype wire

/* mii_data_port.sv */
// Purpose: mii data port of a 10/100 transceiver, phy side
// Assumes: line-side receive inputs are on sys_clk; collision is not
// Notes: rx clock and sourced tx clock come from one sys_clk divider
`default_nettype none

// Behaviour
// - fifth transmit bit is used only in symbol mode, else ignored.
// - device drives the transmit clock unless slave clock mode is set.
// - transmit and receive clocks run 25 MHz at 100 Mbps, 2.5 MHz at 10.
// - transmit error at 100 Mbps sends invalid code symbols to the line.
// - receive data follows receive clock; fifth bit only in symbol mode.
// - receive data valid is raised while valid data is on receive data.
// - receive error is raised when invalid symbols arrive from the medium.
// - receive clock runs continuously and times all receive outputs.
// - collision output stays high for the whole collision.
// - collision output stays low throughout full duplex.
// - half duplex carrier sense outside repeater mode follows transmit or receive activity.
// - full duplex or repeater carrier sense follows receive activity only.
// - repeater mode with tristate control high floats receive outputs.
module mii_data_port
    import mii_port_pkg::*;
(
    // system
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // mii transmit
    input wire logic tx_clk_in,
    output logic tx_clk_out,
    output logic tx_clk_oe,
    input wire logic [4:0] txd,
    input wire logic tx_en,
    input wire logic tx_er,
    // mii receive
    output logic [4:0] rxd,
    output logic [4:0] rxd_oe,
    output logic rx_dv,
    output logic rx_dv_oe,
    output logic rx_er,
    output logic rx_er_oe,
    output logic rx_clk,
    output logic rx_clk_oe,
    // mii status
    output logic col,
    output logic crs,
    input wire logic mii_tristate_control,
    // line side transmit, on tx_clk_in
    output logic [4:0] line_tx_sym,
    output logic line_tx_valid,
    output logic line_tx_invalid,
    // line side receive, on sys_clk except line_collision
    input wire logic [4:0] line_rx_data,
    input wire logic line_rx_valid,
    input wire logic line_rx_invalid,
    input wire logic line_rx_active,
    input wire logic line_collision,
    output logic line_rx_take
);
    import mii_port_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [DIV_W-1:0] half_count(input logic fast);
        half_count = fast ? DIV_W'(HALF_FAST) : DIV_W'(HALF_SLOW);
    endfunction : half_count

    function automatic logic [31:0] read_value(
        input logic [ADDR_W-1:0] addr,
        input core_state_t st,
        input logic isolated
    );
        logic [31:0] v;
        v = '0;
        case (addr)
            ADDR_CTRL: begin
                v[CTRL_W-1:0] = st.ctrl;
            end
            ADDR_STATUS: begin
                v[STAT_CRS] = st.crs;
                v[STAT_COL] = st.col;
                v[STAT_TX_BUSY] = st.busy_s;
                v[STAT_RX_DV] = st.rx_dv;
                v[STAT_ISOLATED] = isolated;
            end
            default: begin
                v = '0;
            end
        endcase
        read_value = v;
    endfunction : read_value

    core_state_t s;
    core_state_t next_s;
    logic wrap;
    logic launch;
    logic isolated;

    tx_link_if link ();

    // ---------------------------------------------------------------
    // transmit side on the link clock
    // ---------------------------------------------------------------
    // the capture runs on the pin level, so in master mode the bench
    // loops tx_clk_out back onto tx_clk_in
    mii_tx_capture u_tx (
        .tx_clk(tx_clk_in),
        .reset_n(reset_n),
        .link(link),
        .txd(txd),
        .tx_en(tx_en),
        .tx_er(tx_er),
        .line_tx_sym(line_tx_sym),
        .line_tx_valid(line_tx_valid),
        .line_tx_invalid(line_tx_invalid)
    );

    assign link.symbol_mode = s.ctrl.symbol_mode;
    assign link.speed_100 = s.ctrl.speed_100;

    // ---------------------------------------------------------------
    // clock divider and launch point
    // ---------------------------------------------------------------
    // a speed change applies at once and a count past the new end wraps on the
    // next cycle, so no runt half period shorter than the fast rate can appear
    assign wrap = s.div >= half_count(s.ctrl.speed_100) - DIV_W'(1);
    assign launch = wrap & s.link_clk;
    assign isolated = s.ctrl.repeater_mode & s.tri_s;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.tri_meta = mii_tristate_control;
        next_s.tri_s = s.tri_meta;
        next_s.col_meta = line_collision;
        next_s.col_s = s.col_meta;
        next_s.busy_meta = link.tx_busy;
        next_s.busy_s = s.busy_meta;
        next_s.take = 1'b0;

        // free running, never gated by traffic
        if (wrap) begin
            next_s.div = '0;
            next_s.link_clk = ~s.link_clk;
        end else begin
            next_s.div = s.div + DIV_W'(1);
        end

        // falling receive clock edge: mac samples on the rising one
        if (launch) begin
            next_s.rxd = {s.ctrl.symbol_mode & line_rx_data[4],
                line_rx_data[3:0]};
            next_s.rx_dv = line_rx_valid;
            next_s.rx_er = line_rx_invalid;
            next_s.take = 1'b1;
        end

        // follows the detector level, so it lasts as the collision does
        next_s.col = s.col_s & ~s.ctrl.full_duplex;

        if (s.ctrl.full_duplex | s.ctrl.repeater_mode) begin
            next_s.crs = line_rx_active;
        end else begin
            next_s.crs = line_rx_active | s.busy_s;
        end

        case (s.bus)
            BUS_IDLE: begin
                if (avs_read | avs_write) begin
                    next_s.bus = BUS_DONE;
                    next_s.readdata = read_value(avs_address, s, isolated);
                end
            end
            BUS_DONE: begin
                next_s.bus = BUS_IDLE;
                if (avs_write && avs_address == ADDR_CTRL) begin
                    next_s.ctrl = ctrl_t'(avs_writedata[CTRL_W-1:0]);
                end
            end
            default: begin
                next_s.bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s <= CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign avs_readdata = s.readdata;
    assign avs_waitrequest = (avs_read | avs_write) & (s.bus != BUS_DONE);

    assign tx_clk_out = s.link_clk;
    assign tx_clk_oe = ~s.ctrl.slave_clock;

    assign rx_clk = s.link_clk;
    assign rx_clk_oe = ~isolated;
    assign rxd = s.rxd;
    assign rxd_oe = {s.ctrl.symbol_mode & ~isolated, {4{~isolated}}};
    assign rx_dv = s.rx_dv;
    assign rx_dv_oe = ~isolated;
    assign rx_er = s.rx_er;
    assign rx_er_oe = ~isolated;

    // registered, so it lags the detector by the synchroniser
    assign col = s.col;
    assign crs = s.crs;
    assign line_rx_take = s.take;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence launch_edge;
        $fell(s.link_clk);
    endsequence

    sequence slow_rise;
        !s.ctrl.speed_100 && $stable(s.ctrl.speed_100) && $rose(s.link_clk);
    endsequence

    a_rx_launch_edge: assert property (
        $changed(s.rxd) || $changed(s.rx_dv) || $changed(s.rx_er)
        |-> launch_edge)
        else $error("receive outputs changed away from the falling edge");

    a_rx_dv_follow: assert property (
        launch_edge |-> rx_dv == $past(line_rx_valid))
        else $error("data valid does not follow the received data");

    a_rx_er_invalid: assert property (
        launch_edge and $past(line_rx_invalid) |-> rx_er)
        else $error("invalid symbol did not raise receive error");

    a_rxd4_nibble: assert property (
        launch_edge and !$past(s.ctrl.symbol_mode) |-> rxd[4] == 1'b0)
        else $error("fifth receive bit driven outside symbol mode");

    a_clk_fast: assert property (
        $past(reset_n) && s.ctrl.speed_100 && $past(s.ctrl.speed_100)
        && $past(s.ctrl.speed_100, 2) |-> $changed(s.link_clk))
        else $error("link clock not at half the system rate");

    a_clk_slow: assert property (
        slow_rise |-> s.link_clk [*8])
        else $error("slow link clock high phase too short");

    a_clk_running: assert property (
        $stable(s.link_clk) |-> ##[1:10] $changed(s.link_clk))
        else $error("receive clock stopped");

    a_col_fdx_off: assert property (
        $past(s.ctrl.full_duplex) |-> !col)
        else $error("collision shown in full duplex");

    a_col_follows: assert property (
        $past(s.col_s && !s.ctrl.full_duplex) |-> col)
        else $error("collision dropped while still present");

    a_crs_half: assert property (
        $past(!s.ctrl.full_duplex && !s.ctrl.repeater_mode
        && (s.busy_s || line_rx_active)) |-> crs)
        else $error("carrier sense missed activity in half duplex");

    a_crs_rx_only: assert property (
        $past((s.ctrl.full_duplex || s.ctrl.repeater_mode)
        && !line_rx_active) |-> !crs)
        else $error("carrier sense raised by transmit alone");

    a_rx_float: assert property (
        isolated |-> !rx_clk_oe && !rx_dv_oe && !rx_er_oe && rxd_oe == '0)
        else $error("receive outputs driven while isolated");

    a_tx_clk_owner: assert property (
        $past(s.ctrl.slave_clock) && s.ctrl.slave_clock |-> !tx_clk_oe)
        else $error("tx clock driven in slave clock mode");

endmodule : mii_data_port

`default_nettype wire

/* mii_mac_model.sv */
// Purpose: mac transmit side facing the phy data port
// Assumes: tx_clk is the resolved transmit clock pin
// Notes: idle data keeps changing so a stale nibble never looks valid
`default_nettype none

module mii_mac_model (
    // transmit clock as seen on the pin
    input wire logic tx_clk,
    // frame control from the bench
    input wire logic go,
    input wire logic err_en,
    // mac transmit pins
    output logic [4:0] txd,
    output logic tx_en,
    output logic tx_er
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // transmit drive, launched on the rising pin edge
    // ---------------------------------------------------------------
    initial begin
        txd = 5'h15;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end

    always @(posedge tx_clk) begin
        if (go) begin
            txd <= 5'($urandom);
            tx_en <= 1'b1;
            tx_er <= err_en & 1'($urandom);
        end else begin
            txd <= ~txd;
            tx_en <= 1'b0;
            tx_er <= 1'b0;
        end
    end
endmodule : mii_mac_model

`default_nettype wire

/* phy_mii_data_port_tb.sv */
// Purpose: self-checking bench of the mii data port
// Assumes: 50 MHz sys_clk, 12 ns bench tx clock in slave clock mode
// Notes: checks are gated off while mode bits cross domains
`default_nettype none

module phy_mii_data_port_tb;
    import mii_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic sys_clk = 1'b0, reset_n, link_clk = 1'b0;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, tx_clk_in, tx_clk_out, tx_clk_oe;
    logic [4:0] txd, rxd, rxd_oe, line_tx_sym, line_rx_data = 5'h0;
    logic tx_en, tx_er, rx_dv, rx_dv_oe, rx_er, rx_er_oe, rx_clk;
    logic rx_clk_oe, col, crs, line_tx_valid, line_tx_invalid, take;
    logic mii_tristate_control = 1'b0, line_rx_valid = 1'b0;
    logic line_rx_invalid = 1'b0, line_rx_active = 1'b0;
    logic line_collision = 1'b0, go = 1'b0, err_en = 1'b0;
    logic link_run = 1'b0, link_gate = 1'b0, chk_tx = 1'b0;
    logic chk_rx = 1'b0, prev_rxclk = 1'b0, per_ok = 1'b0;
    logic [4:0] cur_mode = 5'h01, last_rxd = 5'h0;
    logic [6:0] rx_exp = 7'h0, tx_cap = 7'h0;
    int per = 0, bad_count = 0, samples_checked = 0;
    logic [7:0] oe_all;
    logic [6:0] rx_seen, tx_seen;

    always #10 sys_clk = ~sys_clk;
    always #6 link_clk = ~link_clk;
    // gate on the low phase so the pin never sees a runt pulse
    always @(negedge link_clk) link_gate <= link_run;
    assign tx_clk_in = tx_clk_oe ? tx_clk_out : (link_clk & link_gate);
    assign oe_all = {rxd_oe, rx_dv_oe, rx_er_oe, rx_clk_oe};
    assign rx_seen = {rx_er, rx_dv, rxd};
    assign tx_seen = {line_tx_sym, line_tx_valid, line_tx_invalid};

    mii_data_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_clk_in(tx_clk_in), .tx_clk_out(tx_clk_out),
        .tx_clk_oe(tx_clk_oe), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
        .rxd(rxd), .rxd_oe(rxd_oe), .rx_dv(rx_dv), .rx_dv_oe(rx_dv_oe),
        .rx_er(rx_er), .rx_er_oe(rx_er_oe), .rx_clk(rx_clk),
        .rx_clk_oe(rx_clk_oe), .col(col), .crs(crs),
        .mii_tristate_control(mii_tristate_control),
        .line_tx_sym(line_tx_sym), .line_tx_valid(line_tx_valid),
        .line_tx_invalid(line_tx_invalid), .line_rx_data(line_rx_data),
        .line_rx_valid(line_rx_valid), .line_rx_invalid(line_rx_invalid),
        .line_rx_active(line_rx_active), .line_collision(line_collision),
        .line_rx_take(take));

    mii_mac_model i_mac (.tx_clk(tx_clk_in), .go(go), .err_en(err_en),
        .txd(txd), .tx_en(tx_en), .tx_er(tx_er));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and read data are both taken at the rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 100) bad_count++;
    endtask : bus

    function automatic logic [6:0] tx_exp(input logic [4:0] m,
        input logic [4:0] d, input logic en, input logic er);
        if (!en) return 7'h00;
        if (er & m[0]) return {INVALID_SYM, 2'b11};
        return {m[3] & d[4], d[3:0], 2'b10};
    endfunction : tx_exp

    function automatic logic [31:0] rx_per(input logic [4:0] m);
        return m[0] ? 32'(SYS_CLK_HZ / RATE_FAST_HZ)
                    : 32'(SYS_CLK_HZ / RATE_SLOW_HZ);
    endfunction : rx_per

    task automatic set_mode(input logic [4:0] m);
        logic [31:0] d;
        chk_tx = 1'b0;
        chk_rx = 1'b0;
        bus(1'b1, ADDR_CTRL, 32'(m), d);
        cur_mode = m;
        link_run <= m[4];
        repeat (50) @(posedge sys_clk);
        check("tx clock drive", 32'(tx_clk_oe), 32'(!m[4]));
        chk_tx = 1'b1;
        chk_rx = 1'b1;
    endtask : set_mode

    // ---------------------------------------------------------------
    // receive and transmit monitors
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset_n) begin
            line_rx_data <= 5'($urandom);
            line_rx_valid <= 1'($urandom);
            line_rx_invalid <= 1'($urandom);
        end
    end

    always @(negedge sys_clk) begin
        if (chk_rx) begin
            if (prev_rxclk && !rx_clk) begin
                check("rx data", 32'(rx_seen), 32'(rx_exp));
                check("rx take", 32'(take), 32'h1);
                if (per_ok) begin
                    check("rx period", per, rx_per(cur_mode));
                end
                per = 0;
                per_ok = 1'b1;
            end else begin
                check("rx hold", 32'(rxd), 32'(last_rxd));
                check("rx take idle", 32'(take), 32'h0);
            end
        end else begin
            per_ok = 1'b0;
        end
        per++;
        prev_rxclk = rx_clk;
        last_rxd = rxd;
        rx_exp = {line_rx_invalid, line_rx_valid,
                  cur_mode[3] & line_rx_data[4], line_rx_data[3:0]};
    end

    always @(posedge tx_clk_in) tx_cap = tx_exp(cur_mode, txd, tx_en, tx_er);
    always @(negedge tx_clk_in) begin
        if (chk_tx) check("tx line", 32'(tx_seen), 32'(tx_cap));
    end

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        #400_000;
        bad_count++;
        final_report();
    end

    initial begin
        logic [31:0] d;
        logic [4:0] modes [6];
        modes = '{5'h01, 5'h00, 5'h09, 5'h08, 5'h11, 5'h18};
        void'($urandom(72));
        reset_n <= 1'b0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0, d);
        check("ctrl reset", d, 32'h01);
        bus(1'b1, 4'h8, 32'hffffffff, d);
        bus(1'b0, 4'h8, 32'h0, d);
        check("unmapped", d, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'h1f, d);
        bus(1'b0, ADDR_CTRL, 32'h0, d);
        check("ctrl kept", d, 32'h01);
        // every speed, symbol and clock mode with errors mixed in
        foreach (modes[i]) begin
            set_mode(modes[i]);
            err_en <= 1'b1;
            go <= 1'b1;
            repeat (80) @(posedge sys_clk);
            go <= 1'b0;
            repeat (40) @(posedge sys_clk);
        end
        set_mode(5'h01);
        go <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check("crs half tx", 32'(crs), 32'h1);
        go <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check("crs idle", 32'(crs), 32'h0);
        set_mode(5'h03);
        go <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check("crs full tx", 32'(crs), 32'h0);
        line_rx_active <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("crs full rx", 32'(crs), 32'h1);
        line_rx_active <= 1'b0;
        line_collision <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("col full", 32'(col), 32'h0);
        set_mode(5'h05);
        check("crs repeater tx", 32'(crs), 32'h0);
        go <= 1'b0;
        set_mode(5'h01);
        repeat (8) begin
            @(negedge sys_clk);
            check("col held", 32'(col), 32'h1);
        end
        line_collision <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check("col drop", 32'(col), 32'h0);
        mii_tristate_control <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("oe dte", 32'(oe_all), 32'h7f);
        set_mode(5'h05);
        check("oe float", 32'(oe_all), 32'h00);
        bus(1'b0, ADDR_STATUS, 32'h0, d);
        check("isolated", 32'(d[STAT_ISOLATED]), 32'h1);
        mii_tristate_control <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check("oe back", 32'(oe_all), 32'h7f);
        final_report();
    end
endmodule : phy_mii_data_port_tb

`default_nettype wire
